//--- sim/reset_source_model.sv
// model of the on-chip reset detectors and the reset pin
// assumes the bench requests pulses by a source mask on i_mclk
`timescale 1ns/1ps
`default_nettype none
module reset_source_model
(
   input  wire logic       i_mclk,
   input  wire logic [4:0] i_fire,
   output logic            o_por,
   output logic            o_bor,
   output logic            o_pin,
   output logic            o_wdt,
   output logic            o_irq_wake
);
   // one-cycle pulses, several sources may coincide
   always_ff @(posedge i_mclk)
   begin
      {o_irq_wake, o_wdt, o_pin, o_bor, o_por} <= i_fire;
   end
endmodule
`default_nettype wire

//--- sim/test_reset_state_initializer.sv
// self-checking bench of the reset state initializer
// assumes reset_source_model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_reset_state_initializer;
   typedef struct {
      logic [4:0]  src;
      logic        slp;
      logic [7:0]  ictl;
      logic [12:0] pc;
      logic [7:0]  st;
      logic [1:0]  pw;
      logic [7:0]  opt;
      logic [6:0]  evb;
   } row_t;
   logic        i_mclk, i_reset_n, slp, por, bor, pin, wdt, iwk, irq, pcv;
   logic        awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
   logic [4:0]  fire;
   logic [7:0]  ictl_bits, pir_bits, awaddr, araddr, opt, dira, dirb;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [12:0] pc_low_byte, pcc;
   int          n_fail, total_checks, cyc;
   row_t        rows [9];
   reset_source_model u_src (.i_mclk(i_mclk), .i_fire(fire), .o_por(por), .o_bor(bor),
      .o_pin(pin), .o_wdt(wdt), .o_irq_wake(iwk));
   reset_state_initializer u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_por_event(por),
      .i_bor_event(bor), .i_external_reset_pin(pin), .i_watchdog_unit_timeout(wdt),
      .i_irq_wake(iwk), .i_sleeping(slp), .i_pc_current(pcc),
      .i_irq_ctl_wake_bits(ictl_bits), .i_pir_wake_bits(pir_bits), .o_pc_load(pc_low_byte),
      .o_pc_load_valid(pcv), .o_option_reg(opt), .o_port_a_direction(dira),
      .o_port_b_direction(dirb), .o_irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
   initial
   begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: run did not finish", $time);
         results();
      end
   end
   task automatic results;
      if (n_fail == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
      logic b;
      b = 1'b0;
      awaddr <= a;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!b)
      begin
         @(posedge i_mclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         b = bvalid;
      end
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rr);
      logic got;
      got = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!got)
      begin
         @(posedge i_mclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         got = rvalid;
      end
      dv = rdata;
      rr = rresp;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      axr(a, d, r);
      chk(d, e);
      chk({30'h0, r}, 32'h0);
   endtask
   task automatic ev(input logic [4:0] m);
      int k;
      k = 0;
      fire <= m;
      @(posedge i_mclk);
      fire <= 5'h00;
      while (pcv !== 1'b1 && k < 8)
      begin
         @(posedge i_mclk);
         k++;
      end
      chk({31'h0, pcv}, 32'h1);
   endtask
   initial
   begin
      i_reset_n = 1'b0;
      {fire, slp, ictl_bits, pir_bits, awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, arvalid, n_fail, total_checks, cyc} = '0;
      pcc = 13'h0123;
      rows = '{'{5'h04, 1'b0, 8'h00, 13'h000, 8'h07, 2'h3, 8'hff, 7'h04},
               '{5'h04, 1'b1, 8'h00, 13'h000, 8'h17, 2'h3, 8'hff, 7'h08},
               '{5'h08, 1'b0, 8'h00, 13'h000, 8'h0f, 2'h3, 8'hff, 7'h10},
               '{5'h08, 1'b1, 8'h00, 13'h124, 8'he7, 2'h3, 8'h00, 7'h20},
               '{5'h02, 1'b0, 8'h00, 13'h000, 8'h1f, 2'h2, 8'hff, 7'h02},
               '{5'h10, 1'b1, 8'h00, 13'h124, 8'hf7, 2'h3, 8'h00, 7'h40},
               '{5'h10, 1'b1, 8'h80, 13'h004, 8'hf7, 2'h3, 8'h00, 7'h40},
               '{5'h06, 1'b0, 8'h00, 13'h000, 8'h1f, 2'h2, 8'hff, 7'h02},
               '{5'h03, 1'b0, 8'h00, 13'h000, 8'h1f, 2'h1, 8'hff, 7'h01}};
      repeat (20) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      foreach (rows[i])
      begin
         slp <= rows[i].slp;
         axw(rst_init_pkg::A_STATUS, 32'he7, 2'h0);
         axw(rst_init_pkg::A_PWR, 32'h3, 2'h0);
         axw(rst_init_pkg::A_IRQCTL, {24'h0, rows[i].ictl}, 2'h0);
         axw(rst_init_pkg::A_OPTION, 32'h0, 2'h0);
         axw(rst_init_pkg::A_DIRA, 32'h0, 2'h0);
         axw(rst_init_pkg::A_DIRB, 32'h0, 2'h0);
         axw(rst_init_pkg::A_EVSTAT, 32'h7f, 2'h0);
         ev(rows[i].src);
         chk({19'h0, pc_low_byte}, {19'h0, rows[i].pc});
         slp <= 1'b0;
         rchk(rst_init_pkg::A_PC, {19'h0, rows[i].pc});
         rchk(rst_init_pkg::A_STATUS, {24'h0, rows[i].st});
         rchk(rst_init_pkg::A_PWR, {30'h0, rows[i].pw});
         rchk(rst_init_pkg::A_EVSTAT, {25'h0, rows[i].evb});
         chk({8'h0, opt, dira, dirb}, {8'h0, {3{rows[i].opt}}});
      end
      // wake forcing, wake flags and the event interrupt
      axw(rst_init_pkg::A_EVSTAT, 32'h7f, 2'h0);
      axw(rst_init_pkg::A_EVMASK, 32'h40, 2'h0);
      axw(rst_init_pkg::A_PR2, 32'h0, 2'h0);
      axw(rst_init_pkg::A_ANALOG_SELECT_REG, 32'h0, 2'h0);
      axw(rst_init_pkg::A_CMCTL, 32'h18, 2'h0);
      axw(rst_init_pkg::A_IRQCTL, 32'h0, 2'h0);
      ictl_bits <= 8'h02;
      pir_bits <= 8'h81;
      pcc <= 13'h1fff;
      slp <= 1'b1;
      ev(5'h10);
      chk({19'h0, pc_low_byte}, 32'h0);
      slp <= 1'b0;
      chk({31'h0, irq}, 32'h1);
      rchk(rst_init_pkg::A_PR2, 32'hff);
      rchk(rst_init_pkg::A_ANALOG_SELECT_REG, 32'h7f);
      rchk(rst_init_pkg::A_CMCTL, 32'h1f);
      rchk(rst_init_pkg::A_IRQCTL, 32'h02);
      rchk(rst_init_pkg::A_PIRF, 32'h01);
      rchk(rst_init_pkg::A_EVSTAT, 32'h40);
      axw(rst_init_pkg::A_EVMASK, 32'h0, 2'h0);
      chk({31'h0, irq}, 32'h0);
      axw(rst_init_pkg::A_EVMASK, 32'h40, 2'h0);
      chk({31'h0, irq}, 32'h1);
      axw(rst_init_pkg::A_EVSTAT, 32'h40, 2'h0);
      chk({31'h0, irq}, 32'h0);
      rchk(rst_init_pkg::A_EVSTAT, 32'h0);
      // misaligned write and unmapped read are refused
      axw(8'h05, 32'h0, 2'h3);
      axr(8'h40, d, r);
      chk(d, 32'h0);
      chk({30'h0, r}, 32'h3);
      // second reset in mid-run
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      @(posedge i_mclk);
      chk({7'h0, irq, opt, dira, dirb}, 32'h00ffffff);
      rchk(rst_init_pkg::A_STATUS, 32'h18);
      rchk(rst_init_pkg::A_PWR, 32'h0);
      rchk(rst_init_pkg::A_PR2, 32'hff);
      rchk(rst_init_pkg::A_ANALOG_SELECT_REG, 32'h7f);
      rchk(rst_init_pkg::A_CMCTL, 32'h07);
      rchk(rst_init_pkg::A_EVMASK, 32'h0);
      results();
   end
endmodule
`default_nettype wire

//--- src/reset_state_initializer.sv
// reset and wake-up state initializer with AXI4-Lite register port
// assumes synchronous sources, one clock, software over AXI4-Lite
// Overview of operation
// - power-on clears the pc, status gets timeout and powerdown set with upper bits clear, power-on flag clears.
// - pin reset while running clears pc and the three upper status bits, other status bits and power control kept.
// - pin reset asleep clears pc and upper bits, sets timeout, clears powerdown, keeps the low status bits and power control.
// - interrupt wake continues at pc plus one with timeout set and powerdown clear.
// - interrupt wake with the global enable set loads the interrupt vector instead.
// - timeout and powerdown take values chosen per exact cause.
// - unimplemented register bits read as zero.
// - any true reset loads option and both direction registers with all ones.
// - a wake sets the flag bits in irq control and peripheral flags for its cause.
// - the power-on flag clears only on power-on reset.
// - the brown-out flag clears on brown-out reset and software sets it later.
`timescale 1ns/1ps
`default_nettype none
module reset_state_initializer
(
   input  wire logic        i_mclk,
   input  wire logic        i_reset_n,
   input  wire logic        i_por_event,
   input  wire logic        i_bor_event,
   input  wire logic        i_external_reset_pin,
   input  wire logic        i_watchdog_unit_timeout,
   input  wire logic        i_irq_wake,
   input  wire logic        i_sleeping,
   input  wire logic [12:0] i_pc_current,
   input  wire logic [7:0]  i_irq_ctl_wake_bits,
   input  wire logic [7:0]  i_pir_wake_bits,
   output logic [12:0]      o_pc_load,
   output logic             o_pc_load_valid,
   output logic [7:0]       o_option_reg,
   output logic [7:0]       o_port_a_direction,
   output logic [7:0]       o_port_b_direction,
   output logic             o_irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   rst_event_if evif ();

   rst_event_arb u_arb
   (
      .i_por      (i_por_event),
      .i_bor      (i_bor_event),
      .i_pin      (i_external_reset_pin),
      .i_wdt      (i_watchdog_unit_timeout),
      .i_irq_wake (i_irq_wake),
      .i_sleeping (i_sleeping),
      .ev_o       (evif)
   );

   logic [12:0] pc_q;
   logic [7:0]  status_q;
   logic [1:0]  pwr_q;
   logic [7:0]  option_q;
   logic [7:0]  dira_q;
   logic [7:0]  dirb_q;
   logic [7:0]  pr2_q;
   logic [6:0]  analog_select_reg_q;
   logic [7:0]  cmctl_q;
   logic [7:0]  irqctl_q;
   logic [6:0]  pirf_q;
   logic [6:0]  evstat_q;
   logic [6:0]  evmask_q;
   logic        pcv_q;

   wire rst_class   = evif.valid &
                      (evif.ev inside {rst_init_pkg::EV_POR, rst_init_pkg::EV_BOR,
                                       rst_init_pkg::EV_PIN_RUN, rst_init_pkg::EV_PIN_SLEEP,
                                       rst_init_pkg::EV_WDT_RST});
   wire wake_class  = evif.valid &
                      (evif.ev inside {rst_init_pkg::EV_WDT_WAKE, rst_init_pkg::EV_IRQ_WAKE});
   wire global_irq_enable         = irqctl_q[7];

   // axi write path: address and data may come in either order
   logic        aw_have_q;
   logic        w_have_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
   wire   wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire   sw_wr   = wr_fire & w_strb_q[0];
   wire [7:0] wd  = w_data_q[7:0];

   function automatic logic wr_at(input logic [7:0] a, input logic [7:0] target, input logic en);
      wr_at = en & (a == target);
   endfunction

   wire we_status = wr_at(aw_addr_q, rst_init_pkg::A_STATUS, sw_wr);
   wire we_pwr    = wr_at(aw_addr_q, rst_init_pkg::A_PWR,    sw_wr);
   wire we_option = wr_at(aw_addr_q, rst_init_pkg::A_OPTION, sw_wr);
   wire we_dira   = wr_at(aw_addr_q, rst_init_pkg::A_DIRA,   sw_wr);
   wire we_dirb   = wr_at(aw_addr_q, rst_init_pkg::A_DIRB,   sw_wr);
   wire we_pr2    = wr_at(aw_addr_q, rst_init_pkg::A_PR2,    sw_wr);
   wire we_analog_select_reg  = wr_at(aw_addr_q, rst_init_pkg::A_ANALOG_SELECT_REG,  sw_wr);
   wire we_cmctl  = wr_at(aw_addr_q, rst_init_pkg::A_CMCTL,  sw_wr);
   wire we_irqctl = wr_at(aw_addr_q, rst_init_pkg::A_IRQCTL, sw_wr);
   wire we_pirf   = wr_at(aw_addr_q, rst_init_pkg::A_PIRF,   sw_wr);
   wire we_evstat = wr_at(aw_addr_q, rst_init_pkg::A_EVSTAT, sw_wr);
   wire we_evmask = wr_at(aw_addr_q, rst_init_pkg::A_EVMASK, sw_wr);
   wire wr_known  = (aw_addr_q <= rst_init_pkg::A_EVMASK) & (aw_addr_q[1:0] == 2'h0);

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_addr_q    <= 8'h00;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rst_init_pkg::RESP_OK;
      end
      else
      begin
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? rst_init_pkg::RESP_OK : rst_init_pkg::RESP_DECERR;
         end
         else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // status and power-control per cause
   logic [7:0] status_d;
   logic [1:0] pwr_d;
   logic [12:0] pc_d;
   localparam int NUM_EVW = rst_init_pkg::NUM_EV;
   logic [NUM_EVW-1:0] ev_hit;
   always_comb
   begin
      status_d = we_status ? wd : status_q;
      pwr_d    = we_pwr ? wd[1:0] : pwr_q;
      pc_d     = pc_q;
      ev_hit   = '0;
      case (evif.valid ? evif.ev : rst_init_pkg::EV_NONE)
         rst_init_pkg::EV_POR:
         begin
            pc_d     = rst_init_pkg::PC_RESET;
            status_d = {3'h0, 2'h3, status_q[2:0]};
            pwr_d    = {1'b0, pwr_q[rst_init_pkg::PC_BOR]};
            ev_hit[0] = 1'b1;
         end
         rst_init_pkg::EV_BOR:
         begin
            pc_d     = rst_init_pkg::PC_RESET;
            status_d = {3'h0, 2'h3, status_q[2:0]};
            pwr_d    = {pwr_q[rst_init_pkg::PC_POR], 1'b0};
            ev_hit[1] = 1'b1;
         end
         rst_init_pkg::EV_PIN_RUN:
         begin
            pc_d     = rst_init_pkg::PC_RESET;
            status_d = {3'h0, status_q[4:0]};
            ev_hit[2] = 1'b1;
         end
         rst_init_pkg::EV_PIN_SLEEP:
         begin
            pc_d     = rst_init_pkg::PC_RESET;
            status_d = {3'h0, 2'h2, status_q[2:0]};
            ev_hit[3] = 1'b1;
         end
         rst_init_pkg::EV_WDT_RST:
         begin
            pc_d     = rst_init_pkg::PC_RESET;
            status_d = {3'h0, 2'h1, status_q[2:0]};
            ev_hit[4] = 1'b1;
         end
         rst_init_pkg::EV_WDT_WAKE:
         begin
            pc_d     = i_pc_current + 13'h0001;
            status_d = {status_q[7:5], 2'h0, status_q[2:0]};
            ev_hit[5] = 1'b1;
         end
         rst_init_pkg::EV_IRQ_WAKE:
         begin
            // vector when the global enable is set
            pc_d     = global_irq_enable ? rst_init_pkg::PC_IRQ_VECTOR : i_pc_current + 13'h0001;
            status_d = {status_q[7:5], 2'h2, status_q[2:0]};
            ev_hit[6] = 1'b1;
         end
         default:
         begin
            ev_hit = '0;
         end
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         pc_q     <= rst_init_pkg::PC_RESET;
         status_q <= {3'h0, 2'h3, 3'h0};
         pwr_q    <= 2'h0;
         option_q <= rst_init_pkg::ALL_ONES;
         dira_q   <= rst_init_pkg::ALL_ONES;
         dirb_q   <= rst_init_pkg::ALL_ONES;
         pr2_q    <= rst_init_pkg::ALL_ONES;
         analog_select_reg_q  <= rst_init_pkg::ANALOG_SELECT_REG_ONES;
         cmctl_q  <= {5'h00, rst_init_pkg::CMP_LOW_ONES};
         irqctl_q <= rst_init_pkg::ZERO8;
         pirf_q   <= 7'h00;
         pcv_q    <= 1'b0;
      end
      else
      begin
         pc_q     <= pc_d;
         status_q <= status_d;
         pwr_q    <= pwr_d;
         pcv_q    <= evif.valid;
         if (rst_class)
         begin
            option_q <= rst_init_pkg::ALL_ONES;
            dira_q   <= rst_init_pkg::ALL_ONES;
            dirb_q   <= rst_init_pkg::ALL_ONES;
            pr2_q    <= rst_init_pkg::ALL_ONES;
            analog_select_reg_q  <= rst_init_pkg::ANALOG_SELECT_REG_ONES;
            cmctl_q  <= {5'h00, rst_init_pkg::CMP_LOW_ONES};
            irqctl_q <= rst_init_pkg::ZERO8;
            pirf_q   <= 7'h00;
         end
         else if (wake_class)
         begin
            pr2_q    <= rst_init_pkg::ALL_ONES;
            analog_select_reg_q  <= rst_init_pkg::ANALOG_SELECT_REG_ONES;
            cmctl_q  <= {cmctl_q[7:3], rst_init_pkg::CMP_LOW_ONES};
            irqctl_q <= irqctl_q | i_irq_ctl_wake_bits;
            pirf_q   <= pirf_q | i_pir_wake_bits[6:0];
         end
         else
         begin
            if (we_option) option_q <= wd;
            if (we_dira)   dira_q   <= wd;
            if (we_dirb)   dirb_q   <= wd;
            if (we_pr2)    pr2_q    <= wd;
            if (we_analog_select_reg)  analog_select_reg_q  <= wd[6:0];
            if (we_cmctl)  cmctl_q  <= wd;
            if (we_irqctl) irqctl_q <= wd;
            if (we_pirf)   pirf_q   <= wd[6:0];
         end
      end
   end

   // sticky event status, write one to clear, set wins
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         evstat_q <= 7'h00;
         evmask_q <= 7'h00;
      end
      else
      begin
         evstat_q <= (evstat_q & ~(we_evstat ? wd[6:0] : 7'h00)) | ev_hit;
         if (we_evmask)
            evmask_q <= wd[6:0];
      end
   end
   assign o_irq = |(evstat_q & evmask_q);

   // read path, narrow registers zero-extended
   logic [31:0] rd_mux;
   always_comb
   begin
      case (s_axi_araddr)
         rst_init_pkg::A_PC:     rd_mux = {19'h0, pc_q};
         rst_init_pkg::A_STATUS: rd_mux = {24'h0, status_q};
         rst_init_pkg::A_PWR:    rd_mux = {30'h0, pwr_q};
         rst_init_pkg::A_OPTION: rd_mux = {24'h0, option_q};
         rst_init_pkg::A_DIRA:   rd_mux = {24'h0, dira_q};
         rst_init_pkg::A_DIRB:   rd_mux = {24'h0, dirb_q};
         rst_init_pkg::A_PR2:    rd_mux = {24'h0, pr2_q};
         rst_init_pkg::A_ANALOG_SELECT_REG:  rd_mux = {25'h0, analog_select_reg_q};
         rst_init_pkg::A_CMCTL:  rd_mux = {24'h0, cmctl_q};
         rst_init_pkg::A_IRQCTL: rd_mux = {24'h0, irqctl_q};
         rst_init_pkg::A_PIRF:   rd_mux = {25'h0, pirf_q};
         rst_init_pkg::A_EVSTAT: rd_mux = {25'h0, evstat_q};
         rst_init_pkg::A_EVMASK: rd_mux = {25'h0, evmask_q};
         default:                rd_mux = 32'h0000_0000;
      endcase
   end
   wire rd_known = (s_axi_araddr <= rst_init_pkg::A_EVMASK) & (s_axi_araddr[1:0] == 2'h0);
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= rst_init_pkg::RESP_OK;
      end
      else if (s_axi_arvalid & s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_known ? rst_init_pkg::RESP_OK : rst_init_pkg::RESP_DECERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   assign o_pc_load          = pc_q;
   assign o_pc_load_valid    = pcv_q;
   assign o_option_reg       = option_q;
   assign o_port_a_direction = dira_q;
   assign o_port_b_direction = dirb_q;

   // checks
   por_status_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      evif.valid && evif.ev == rst_init_pkg::EV_POR |=> pc_q == 13'h0000 && status_q[7:3] == 5'h03
      && !pwr_q[1]) else $error("power-on state wrong");
   pin_run_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      evif.valid && evif.ev == rst_init_pkg::EV_PIN_RUN |=> status_q[7:5] == 3'h0
      && status_q[4:0] == $past(status_q[4:0]) && pwr_q == $past(pwr_q))
      else $error("pin reset while running wrong");
   pin_sleep_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      evif.valid && evif.ev == rst_init_pkg::EV_PIN_SLEEP |=> status_q[7:3] == 5'h02
      && pc_q == 13'h0000) else $error("pin reset asleep wrong");
   irq_wake_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      evif.valid && evif.ev == rst_init_pkg::EV_IRQ_WAKE && !global_irq_enable |=>
      pc_q == $past(i_pc_current) + 13'h0001 && status_q[4:3] == 2'h2)
      else $error("interrupt wake wrong");
   irq_vector_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      evif.valid && evif.ev == rst_init_pkg::EV_IRQ_WAKE && global_irq_enable |=> pc_q == 13'h0004)
      else $error("vector not loaded");
   wdt_flags_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      evif.valid && evif.ev == rst_init_pkg::EV_WDT_RST |=> status_q[4:3] == 2'h1)
      else $error("watchdog flags wrong");
   dir_ones_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      rst_class |=> o_port_a_direction == 8'hff && o_port_b_direction == 8'hff
      && o_option_reg == 8'hff) else $error("directions not inputs");
   wake_force_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      wake_class |=> pr2_q == 8'hff && cmctl_q[2:0] == 3'h7 && analog_select_reg_q == 7'h7f)
      else $error("wake forcing wrong");
   por_flag_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      evif.valid && evif.ev != rst_init_pkg::EV_POR && !we_pwr |=> pwr_q[1] == $past(pwr_q[1]))
      else $error("power-on flag disturbed");
   bor_flag_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      evif.valid && evif.ev == rst_init_pkg::EV_BOR |=> !pwr_q[0])
      else $error("brown-out flag not cleared");
   prio_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      i_por_event |-> evif.ev == rst_init_pkg::EV_POR) else $error("priority wrong");
endmodule
`default_nettype wire

//--- src/rst_event_arb.sv
// priority arbiter of the reset and wake-up sources
// assumes all sources synchronous pulses or levels on i_mclk
`timescale 1ns/1ps
`default_nettype none
module rst_event_arb
(
   input  wire logic    i_por,
   input  wire logic    i_bor,
   input  wire logic    i_pin,
   input  wire logic    i_wdt,
   input  wire logic    i_irq_wake,
   input  wire logic    i_sleeping,
   rst_event_if.src     ev_o
);
   // power-on first, then brown-out, then pin, then watchdog, then interrupt wake
   assign ev_o.valid = i_por | i_bor | i_pin | i_wdt | (i_irq_wake & i_sleeping);
   assign ev_o.ev =
      i_por                      ? rst_init_pkg::EV_POR :
      i_bor                      ? rst_init_pkg::EV_BOR :
      (i_pin &  i_sleeping)      ? rst_init_pkg::EV_PIN_SLEEP :
      i_pin                      ? rst_init_pkg::EV_PIN_RUN :
      (i_wdt &  i_sleeping)      ? rst_init_pkg::EV_WDT_WAKE :
      i_wdt                      ? rst_init_pkg::EV_WDT_RST :
      (i_irq_wake & i_sleeping)  ? rst_init_pkg::EV_IRQ_WAKE :
                                   rst_init_pkg::EV_NONE;
endmodule
`default_nettype wire

//--- src/rst_event_if.sv
// interface carrying the resolved reset event from the arbiter
// assumes both ends sit on one clock
`timescale 1ns/1ps
`default_nettype none
interface rst_event_if;
   logic                 valid;
   rst_init_pkg::event_t ev;
   modport src (output valid, output ev);
   modport dst (input valid, input ev);
endinterface
`default_nettype wire

//--- src/rst_init_pkg.sv
// package of constants for the reset state initializer
// assumes one 25 MHz clock and an AXI4-Lite register port
package rst_init_pkg;
   localparam logic [12:0] PC_RESET       = 13'h0000;
   localparam logic [12:0] PC_IRQ_VECTOR  = 13'h0004;
   localparam logic [7:0]  ALL_ONES       = 8'hff;
   localparam logic [7:0]  ZERO8          = 8'h00;
   localparam logic [6:0]  ANALOG_SELECT_REG_ONES     = 7'h7f;
   localparam logic [2:0]  CMP_LOW_ONES   = 3'h7;
   // status bit positions
   localparam int ST_PD   = 3;
   localparam int ST_TO   = 4;
   // power-control bit positions
   localparam int PC_BOR  = 0;
   localparam int PC_POR  = 1;
   // register offsets (byte addresses)
   localparam logic [7:0] A_PC      = 8'h00;
   localparam logic [7:0] A_STATUS  = 8'h04;
   localparam logic [7:0] A_PWR     = 8'h08;
   localparam logic [7:0] A_OPTION  = 8'h0c;
   localparam logic [7:0] A_DIRA    = 8'h10;
   localparam logic [7:0] A_DIRB    = 8'h14;
   localparam logic [7:0] A_PR2     = 8'h18;
   localparam logic [7:0] A_ANALOG_SELECT_REG   = 8'h1c;
   localparam logic [7:0] A_CMCTL   = 8'h20;
   localparam logic [7:0] A_IRQCTL  = 8'h24;
   localparam logic [7:0] A_PIRF    = 8'h28;
   localparam logic [7:0] A_EVSTAT  = 8'h2c;
   localparam logic [7:0] A_EVMASK  = 8'h30;
   localparam logic [1:0] RESP_OK     = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam int NUM_EV = 7;
   typedef enum logic [2:0] {
      EV_NONE, EV_POR, EV_BOR, EV_PIN_RUN, EV_PIN_SLEEP, EV_WDT_RST, EV_WDT_WAKE, EV_IRQ_WAKE
   } event_t;
endpackage
